// ### design/ssba_map.svh
`ifndef SSBA_MAP_SVH
`define SSBA_MAP_SVH

// -------------------------------------------------------------------
// control space decode on latched address bits 4:3
// -------------------------------------------------------------------
`define SSBA_SEL_HI 4
`define SSBA_SEL_LO 3
`define SSBA_REG_CTLR 2'h0
`define SSBA_REG_CNT 2'h1
`define SSBA_REG_PORT 2'h2

// -------------------------------------------------------------------
// reset control port fields and reset values
// -------------------------------------------------------------------
`define SSBA_PORT_C 0
`define SSBA_PORT_B 1
`define SSBA_PORT_S 2
`define SSBA_PORT_E 3
`define SSBA_PORT_W 7
`define SSBA_PORT_RST 7'h00
`define SSBA_CNT_RST 16'h0000

// -------------------------------------------------------------------
// timing
// -------------------------------------------------------------------
`define SSBA_CLK_PERIOD_NS 25
`define SSBA_CTL_STB_NS 200
`define SSBA_CTL_STB_CYC ((`SSBA_CTL_STB_NS + `SSBA_CLK_PERIOD_NS - 1) / `SSBA_CLK_PERIOD_NS)

// -------------------------------------------------------------------
// sizes
// -------------------------------------------------------------------
`define SSBA_FIFO_DEPTH 4
`define SSBA_SYNC_W 12

`endif

// ### design/ssba_pkg.sv
package ssba_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_HOST = 5'h02,
    ST_CTL = 5'h04,
    ST_DBA = 5'h08,
    ST_THR = 5'h10
  } ssba_state_e;
  typedef logic [15:0] ssba_waddr_t;
endpackage

// ### design/ssba_fifo.sv
module ssba_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem [0:D-1];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign o_in_ready = (count != (AW+1)'(D));
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ### design/ssba_arbiter.sv
`include "ssba_map.svh"

module ssba_arbiter (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_host_req,
  input wire logic i_host_buf_sel,
  input wire logic i_host_wr,
  input wire logic i_host_byte,
  input wire logic [17:0] i_host_la,
  input wire logic [31:0] i_host_wdata,
  output logic [31:0] o_host_rdata,
  output logic o_host_ack,
  output logic o_host_gnt,
  output logic o_dba_gnt,
  output logic o_dba_ready,
  input wire logic i_dba_req,
  input wire logic i_dba_dir,
  input wire logic i_dba_stb,
  input wire logic [7:0] i_ctl_din,
  output logic [7:0] o_ctl_dout,
  output logic o_ctl_doe,
  output logic o_ctl_cs_n,
  output logic o_ctl_rd_n,
  output logic o_ctl_wr_n,
  output logic o_ctl_a0,
  output logic o_ctl_rst,
  input wire logic i_scsi_rst_in,
  output logic o_scsi_rst,
  output logic [7:0] o_mem_row,
  output logic [7:0] o_mem_col
);
  localparam logic [3:0] STB_LAST = 4'(`SSBA_CTL_STB_CYC - 1);

  // -----------------------------------------------------------------
  // signals
  // -----------------------------------------------------------------
  ssba_pkg::ssba_state_e state;
  ssba_pkg::ssba_state_e next_state;
  logic [31:0] buf_mem [0:65535];
  logic [`SSBA_SYNC_W-1:0] sync_a;
  logic [`SSBA_SYNC_W-1:0] sync_b;
  logic [7:0] din_s;
  logic req_s;
  logic stb_s;
  logic dir_s;
  logic srst_s;
  logic stb_d;
  logic stb_rise;
  ssba_pkg::ssba_waddr_t addr_cnt;
  ssba_pkg::ssba_waddr_t sel_addr;
  logic [1:0] bcnt;
  logic [23:0] asm_q;
  logic [31:0] rd_word;
  logic [3:0] stb_cnt;
  logic [`SSBA_PORT_W-1:0] port;
  logic dba_block;
  logic [1:0] region;
  logic ctl_done;
  logic cnt_wr;
  logic port_wr;
  logic f_in_valid;
  logic f_in_ready;
  logic [7:0] f_in_data;
  logic f_out_valid;
  logic f_out_ready;
  logic [7:0] f_out_data;
  logic push_fire;
  logic pop_fire;
  logic funnel_step;

  function automatic logic [7:0] byte_of(input logic [31:0] word, input logic [1:0] lane);
    byte_of = word[{lane, 3'h0} +: 8];
  endfunction

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      sync_a <= '0;
      sync_b <= '0;
      stb_d <= 1'b0;
    end else begin
      sync_a <= {i_scsi_rst_in, i_dba_dir, i_dba_stb, i_dba_req, i_ctl_din};
      sync_b <= sync_a;
      stb_d <= stb_s;
    end
  end

  assign din_s = sync_b[7:0];
  assign req_s = sync_b[8];
  assign stb_s = sync_b[9];
  assign dir_s = sync_b[10];
  assign srst_s = sync_b[11];
  assign stb_rise = stb_s & ~stb_d;

  // -----------------------------------------------------------------
  // ownership arbitration
  // -----------------------------------------------------------------
  assign region = i_host_la[`SSBA_SEL_HI:`SSBA_SEL_LO];
  assign ctl_done = (state == ssba_pkg::ST_CTL) && (stb_cnt == STB_LAST);
  assign cnt_wr = ctl_done & i_host_wr & (region == `SSBA_REG_CNT);
  assign port_wr = ctl_done & i_host_wr & (region == `SSBA_REG_PORT);

  always_comb begin
    next_state = state;
    unique case (state)
      ssba_pkg::ST_IDLE: begin
        // host wins a tie so a throttled controller cannot grab back
        if (i_host_req && !o_host_ack) begin
          next_state = i_host_buf_sel ? ssba_pkg::ST_HOST : ssba_pkg::ST_CTL;
        end else if (req_s && !dba_block) begin
          next_state = ssba_pkg::ST_DBA;
        end
      end
      ssba_pkg::ST_HOST: next_state = ssba_pkg::ST_IDLE;
      ssba_pkg::ST_CTL: begin
        if (stb_cnt == STB_LAST) begin
          next_state = ssba_pkg::ST_IDLE;
        end
      end
      ssba_pkg::ST_DBA: begin
        if (i_host_req || !req_s || dba_block) begin
          next_state = ssba_pkg::ST_THR;
        end
      end
      ssba_pkg::ST_THR: next_state = ssba_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state <= ssba_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_host_gnt <= 1'b0;
      o_dba_gnt <= 1'b0;
    end else begin
      o_host_gnt <= (next_state == ssba_pkg::ST_HOST);
      o_dba_gnt <= (next_state == ssba_pkg::ST_DBA);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      dba_block <= 1'b0;
    end else if (port_wr) begin
      dba_block <= 1'b1;
    end else if (!req_s) begin
      dba_block <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // address selection and buffer
  // -----------------------------------------------------------------
  // owner picks address
  assign sel_addr = (state == ssba_pkg::ST_HOST) ? i_host_la[17:2] : addr_cnt;
  assign rd_word = buf_mem[sel_addr];

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_mem_row <= 8'h00;
      o_mem_col <= 8'h00;
    end else begin
      o_mem_row <= sel_addr[15:8];
      o_mem_col <= sel_addr[7:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (state == ssba_pkg::ST_HOST && i_host_wr) begin
      if (i_host_byte) begin
        buf_mem[sel_addr][{i_host_la[1:0], 3'h0} +: 8] <= i_host_wdata[7:0];
      end else begin
        buf_mem[sel_addr] <= i_host_wdata;
      end
    end else if (dir_s && funnel_step && bcnt == 2'h3) begin
      buf_mem[addr_cnt] <= {f_out_data, asm_q};
    end
  end

  // -----------------------------------------------------------------
  // byte funnel
  // -----------------------------------------------------------------
  // both directions share one fifo
  assign f_in_valid = dir_s ? stb_rise : (state == ssba_pkg::ST_DBA);
  assign f_in_data = dir_s ? din_s : byte_of(rd_word, bcnt);
  assign f_out_ready = dir_s ? (state == ssba_pkg::ST_DBA) : stb_rise;
  assign push_fire = f_in_valid & f_in_ready;
  assign pop_fire = f_out_valid & f_out_ready;
  assign funnel_step = dir_s ? pop_fire : push_fire;

  // flush on counter load
  // prefetched read bytes would otherwise lead the next transfer
  ssba_fifo #(
    .W(8),
    .D(`SSBA_FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rstn(i_rstn & ~cnt_wr),
    .i_in_valid(f_in_valid),
    .o_in_ready(f_in_ready),
    .i_in_data(f_in_data),
    .o_out_valid(f_out_valid),
    .i_out_ready(f_out_ready),
    .o_out_data(f_out_data)
  );

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      asm_q <= 24'h000000;
    end else if (dir_s && pop_fire && bcnt != 2'h3) begin
      asm_q[{bcnt, 3'h0} +: 8] <= f_out_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      addr_cnt <= `SSBA_CNT_RST;
      bcnt <= 2'h0;
    end else if (cnt_wr) begin
      addr_cnt <= i_host_wdata[15:0];
      bcnt <= 2'h0;
    end else if (funnel_step) begin
      bcnt <= bcnt + 2'h1;
      if (bcnt == 2'h3) begin
        addr_cnt <= addr_cnt + 16'h0001;
      end
    end
  end

  // full fifo stalls the controller's incoming bytes
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_dba_ready <= 1'b0;
    end else begin
      o_dba_ready <= f_in_ready;
    end
  end

  // -----------------------------------------------------------------
  // controller port and control space
  // -----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn || state != ssba_pkg::ST_CTL) begin
      stb_cnt <= 4'h0;
    end else begin
      stb_cnt <= stb_cnt + 4'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_ctl_cs_n <= 1'b1;
      o_ctl_rd_n <= 1'b1;
      o_ctl_wr_n <= 1'b1;
      o_ctl_a0 <= 1'b0;
      o_ctl_dout <= 8'h00;
      o_ctl_doe <= 1'b0;
    end else begin
      o_ctl_cs_n <= !(next_state == ssba_pkg::ST_CTL && region == `SSBA_REG_CTLR);
      o_ctl_rd_n <= !(next_state == ssba_pkg::ST_CTL && region == `SSBA_REG_CTLR
                      && !i_host_wr);
      o_ctl_wr_n <= !(next_state == ssba_pkg::ST_CTL && region == `SSBA_REG_CTLR
                      && i_host_wr);
      o_ctl_a0 <= i_host_la[2];
      o_ctl_dout <= (next_state == ssba_pkg::ST_CTL) ? i_host_wdata[7:0] : f_out_data;
      o_ctl_doe <= (next_state == ssba_pkg::ST_CTL && region == `SSBA_REG_CTLR
                    && i_host_wr) || (!dir_s && state == ssba_pkg::ST_DBA);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_host_ack <= 1'b0;
      o_host_rdata <= 32'h00000000;
    end else begin
      o_host_ack <= (state == ssba_pkg::ST_HOST) || ctl_done;
      if (state == ssba_pkg::ST_HOST && !i_host_wr) begin
        o_host_rdata <= i_host_byte ? {24'h000000, byte_of(rd_word, i_host_la[1:0])}
                                    : rd_word;
      end else if (ctl_done && !i_host_wr) begin
        unique case (region)
          `SSBA_REG_CTLR: o_host_rdata <= {24'h000000, din_s};
          `SSBA_REG_CNT: o_host_rdata <= {16'h0000, addr_cnt};
          `SSBA_REG_PORT: o_host_rdata <= {25'h0000000, port};
          default: o_host_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      port <= `SSBA_PORT_RST;
      o_ctl_rst <= 1'b0;
      o_scsi_rst <= 1'b0;
    end else begin
      if (port_wr) begin
        port <= i_host_wdata[`SSBA_PORT_W-1:0];
      end
      o_ctl_rst <= port[`SSBA_PORT_S] ? (port[`SSBA_PORT_E] & srst_s) : port[`SSBA_PORT_C];
      o_scsi_rst <= !port[`SSBA_PORT_S] && port[`SSBA_PORT_B];
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  a_grant_exclusive: assert property (!(o_host_gnt && o_dba_gnt))
    else $error("host and controller granted together");
  a_throttle_host: assert property (
    state == ssba_pkg::ST_DBA && i_host_req |=> state == ssba_pkg::ST_THR ##1
    state == ssba_pkg::ST_IDLE ##1 (state == ssba_pkg::ST_HOST || state == ssba_pkg::ST_CTL))
    else $error("host not granted after throttle");
  a_dba_addr: assert property (state == ssba_pkg::ST_DBA |-> sel_addr == addr_cnt)
    else $error("direct access not using counter");
  a_host_addr: assert property (state == ssba_pkg::ST_HOST |-> sel_addr == i_host_la[17:2])
    else $error("host entry address wrong");
  a_row_col: assert property (1'b1 |=> {o_mem_row, o_mem_col} == $past(sel_addr))
    else $error("row and column halves wrong");
  a_cnt_load: assert property (cnt_wr |=> addr_cnt == $past(i_host_wdata[15:0]) && bcnt == 2'h0)
    else $error("counter load or byte clear wrong");
  a_cnt_step: assert property (
    funnel_step && bcnt == 2'h3 && !cnt_wr |=> addr_cnt == $past(addr_cnt) + 16'h0001)
    else $error("counter did not advance after four bytes");
  a_port_preempt: assert property (port_wr |=> !o_dba_gnt [*2])
    else $error("direct access not preempted by port write");
  a_ctl_strobe: assert property (
    $fell(o_ctl_cs_n) |-> !o_ctl_cs_n [*8] ##1 o_ctl_cs_n)
    else $error("controller strobe length wrong");
  a_bus_reset: assert property (
    port_wr ##1 1'b1 |=> o_scsi_rst == (!port[`SSBA_PORT_S] && port[`SSBA_PORT_B]))
    else $error("bus reset not following port");

  c_host_word: cover property (state == ssba_pkg::ST_HOST && i_host_wr && !i_host_byte);
  c_throttle: cover property (state == ssba_pkg::ST_THR ##2 state == ssba_pkg::ST_HOST);
  c_word_done: cover property (funnel_step && bcnt == 2'h3);
  c_fifo_full: cover property (!f_in_ready);
endmodule

// ### testbench/ssba_ctl_model.sv
module ssba_ctl_model #(
  parameter logic [7:0] AUX = 8'h5A
) (
  input wire logic i_clk,
  input wire logic i_gnt,
  input wire logic i_ready,
  input wire logic [7:0] i_dout,
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic i_a0,
  output logic o_req,
  output logic o_dir,
  output logic o_stb,
  output logic [7:0] o_din
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ptr_reg;
  logic [7:0] data_reg;
  logic [7:0] dba_byte;
  logic dba_drive;
  logic [7:0] tx_q [8];
  logic [7:0] rx_q [$];

  initial begin
    o_req = 1'b0;
    o_dir = 1'b0;
    o_stb = 1'b0;
    o_din = 8'h00;
    dba_drive = 1'b0;
    dba_byte = 8'h00;
  end

  // ------------------------------------------------
  // register window and data bus
  // ------------------------------------------------
  always @(posedge i_clk) begin
    if (!i_cs_n && !i_rd_n) begin
      o_din <= i_a0 ? data_reg : AUX;
    end else if (dba_drive) begin
      o_din <= dba_byte;
    end else begin
      // idle bus toggles so stale bytes never match
      o_din <= ~o_din;
    end
    if (!i_cs_n && !i_wr_n && i_a0) begin
      data_reg <= i_dout;
    end
    if (!i_cs_n && !i_wr_n && !i_a0) begin
      ptr_reg <= i_dout;
    end
  end

  // ------------------------------------------------
  // direct access requests and byte strobes
  // ------------------------------------------------
  task automatic hold_req(input logic dir);
    @(posedge i_clk);
    o_dir <= dir;
    o_req <= 1'b1;
  endtask

  task automatic drop_req;
    @(posedge i_clk);
    o_req <= 1'b0;
  endtask

  // one byte per strobe, held while full
  task automatic xfer(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      repeat (8) @(posedge i_clk);
      k = 0;
      do begin
        @(negedge i_clk);
        k++;
      end while (((o_dir && i_ready !== 1'b1) || i_gnt !== 1'b1) && k < 200);
      if (!o_dir) begin
        rx_q.push_back(i_dout);
      end
      @(posedge i_clk);
      dba_byte <= tx_q[i];
      dba_drive <= o_dir;
      // data leads the strobe through the synchronisers
      repeat (2) @(posedge i_clk);
      o_stb <= 1'b1;
      repeat (3) @(posedge i_clk);
      o_stb <= 1'b0;
      dba_drive <= 1'b0;
    end
  endtask
endmodule

// ### testbench/tb_scsi_shared_buffer_arbiter.sv
module tb_scsi_shared_buffer_arbiter;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_rstn, req, bsel, wr, byt, dreq, ddir, dstb, srst;
  logic ack, hgnt, dgnt, drdy, doe, cs_n, rd_n, wr_n, a0, crst, brst;
  logic [17:0] la;
  logic [31:0] wd, rd, w;
  logic [7:0] din, dout, row, col;
  logic [15:0] c;
  logic [15:0] ent [8];
  logic [31:0] mem [8];
  logic [31:0] ow [2];
  int err_total, compares, cyc;

  ssba_arbiter i_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_host_req(req),
    .i_host_buf_sel(bsel), .i_host_wr(wr), .i_host_byte(byt), .i_host_la(la),
    .i_host_wdata(wd), .o_host_rdata(rd), .o_host_ack(ack), .o_host_gnt(hgnt),
    .o_dba_gnt(dgnt), .o_dba_ready(drdy), .i_dba_req(dreq), .i_dba_dir(ddir),
    .i_dba_stb(dstb), .i_ctl_din(din), .o_ctl_dout(dout), .o_ctl_doe(doe),
    .o_ctl_cs_n(cs_n), .o_ctl_rd_n(rd_n), .o_ctl_wr_n(wr_n), .o_ctl_a0(a0),
    .o_ctl_rst(crst), .i_scsi_rst_in(srst), .o_scsi_rst(brst), .o_mem_row(row),
    .o_mem_col(col));

  ssba_ctl_model i_ctl (.i_clk(i_clk), .i_gnt(dgnt), .i_ready(drdy), .i_dout(dout),
    .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_a0(a0), .o_req(dreq),
    .o_dir(ddir), .o_stb(dstb), .o_din(din));

  always #12.5 i_clk = ~i_clk;

  // ------------------------------------------------
  // checking and closing
  // ------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  function automatic logic [31:0] put_byte(input logic [31:0] v, input logic [1:0] ln,
                                           input logic [7:0] b);
    put_byte = v;
    put_byte[ln*8 +: 8] = b;
  endfunction

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_of_test;
    end
  end

  always @(negedge i_clk) begin
    if (hgnt === 1'b1 || dgnt === 1'b1) chk({31'h0, hgnt & dgnt}, 32'h0);
  end

  // ------------------------------------------------
  // host cycles and direct access helpers
  // ------------------------------------------------
  task automatic host(input logic s, input logic wv, input logic bv, input logic [17:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    logic g;
    logic e;
    @(posedge i_clk);
    req <= 1'b1;
    bsel <= s;
    wr <= wv;
    byt <= bv;
    la <= a;
    wd <= d;
    n = 0;
    g = 1'b0;
    e = 1'b0;
    do begin
      @(negedge i_clk);
      n++;
      if (hgnt === 1'b1) g = 1'b1;
      if (doe === 1'b1) e = 1'b1;
    end while (ack !== 1'b1 && n < 400);
    chk({31'h0, ack}, 32'h1);
    chk({31'h0, g}, {31'h0, s});
    chk({31'h0, e}, {31'h0, ~s & wv & (a[4:3] == 2'h0)});
    q = rd;
    if (s) chk({16'h0, row, col}, {16'h0, a[17:2]});
    @(posedge i_clk);
    req <= 1'b0;
  endtask

  task automatic wait_gnt;
    int n;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (dgnt !== 1'b1 && n < 100);
    chk({31'h0, dgnt}, 32'h1);
  endtask

  task automatic dba(input logic dir, input int n);
    i_ctl.hold_req(dir);
    i_ctl.xfer(n);
    repeat (12) @(posedge i_clk);
    i_ctl.drop_req();
    repeat (8) @(posedge i_clk);
  endtask

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    i_clk = 1'b0;
    i_rstn = 1'b0;
    {req, bsel, wr, byt, srst} = 5'h00;
    la = 18'h00000;
    wd = 32'h00000000;
    err_total = 0;
    compares = 0;
    cyc = 0;
    void'($urandom(32'h6778992D));
    repeat (15) @(posedge i_clk);
    @(negedge i_clk);
    chk({23'h0, doe, hgnt, cs_n, rd_n, wr_n, ack, dgnt, brst, crst}, 32'h070);
    chk({row, col, dout, 7'h0, drdy}, 32'h0);
    chk(rd, 32'h0);
    @(posedge i_clk);
    i_rstn <= 1'b1;
    $display("test reset done");

    ent[0] = 16'h0000;
    ent[1] = 16'hFFFF;
    for (int i = 2; i < 8; i++) ent[i] = {12'($urandom), 4'(i)};
    for (int i = 0; i < 8; i++) begin
      mem[i] = $urandom;
      host(1'b1, 1'b1, 1'b0, {ent[i], 2'h0}, mem[i], rd);
    end
    for (int i = 0; i < 8; i++) begin
      host(1'b1, 1'b0, 1'b0, {ent[i], 2'h0}, 32'h0, rd);
      chk(rd, mem[i]);
    end
    for (int l = 0; l < 4; l++) begin
      w = $urandom;
      host(1'b1, 1'b1, 1'b1, {ent[2], 2'(l)}, w, rd);
      mem[2] = put_byte(mem[2], 2'(l), w[7:0]);
      host(1'b1, 1'b0, 1'b1, {ent[2], 2'(l)}, 32'h0, rd);
      chk(rd, {24'h0, w[7:0]});
      host(1'b1, 1'b0, 1'b0, {ent[2], 2'h0}, 32'h0, rd);
      chk(rd, mem[2]);
    end
    $display("test host buffer done");

    // lowest controller pair only
    w = $urandom;
    host(1'b0, 1'b1, 1'b0, 18'h00008, w, rd);
    host(1'b0, 1'b0, 1'b0, 18'h00008, 32'h0, rd);
    chk({16'h0, rd[15:0]}, {16'h0, w[15:0]});
    host(1'b0, 1'b1, 1'b0, 18'h00000, w, rd);
    chk({24'h0, i_ctl.ptr_reg}, {24'h0, w[7:0]});
    host(1'b0, 1'b0, 1'b0, 18'h00000, 32'h0, rd);
    chk({24'h0, rd[7:0]}, 32'h5A);
    host(1'b0, 1'b1, 1'b0, 18'h00004, ~w, rd);
    host(1'b0, 1'b0, 1'b0, 18'h00004, 32'h0, rd);
    chk({24'h0, rd[7:0]}, {24'h0, ~w[7:0]});
    host(1'b0, 1'b0, 1'b0, 18'h00018, 32'h0, rd);
    chk(rd, 32'h0);
    $display("test control space done");

    // counter preset before each transfer; a short burst first
    c = 16'($urandom);
    host(1'b0, 1'b1, 1'b0, 18'h00008, {16'h0, c}, rd);
    for (int i = 0; i < 8; i++) i_ctl.tx_q[i] = 8'($urandom);
    dba(1'b1, 2);
    c = c + 16'h0010;
    host(1'b0, 1'b1, 1'b0, 18'h00008, {16'h0, c}, rd);
    for (int i = 0; i < 8; i++) i_ctl.tx_q[i] = 8'($urandom);
    dba(1'b1, 8);
    for (int k = 0; k < 2; k++) begin
      host(1'b1, 1'b0, 1'b0, {16'(c + k), 2'h0}, 32'h0, rd);
      chk(rd, {i_ctl.tx_q[4*k+3], i_ctl.tx_q[4*k+2], i_ctl.tx_q[4*k+1],
               i_ctl.tx_q[4*k]});
    end
    host(1'b0, 1'b0, 1'b0, 18'h00008, 32'h0, rd);
    chk({16'h0, rd[15:0]}, {16'h0, 16'(c + 16'h0002)});
    $display("test direct write done");

    c = 16'($urandom);
    for (int k = 0; k < 2; k++) begin
      ow[k] = $urandom;
      host(1'b1, 1'b1, 1'b0, {16'(c + k), 2'h0}, ow[k], rd);
    end
    host(1'b0, 1'b1, 1'b0, 18'h00008, {16'h0, c}, rd);
    i_ctl.rx_q.delete();
    dba(1'b0, 8);
    for (int i = 0; i < 8; i++) begin
      chk({24'h0, i_ctl.rx_q[i]}, {24'h0, ow[i/4][8*(i%4) +: 8]});
    end
    $display("test direct read done");

    i_ctl.hold_req(1'b1);
    wait_gnt();
    host(1'b1, 1'b0, 1'b0, {ent[0], 2'h0}, 32'h0, rd);
    chk(rd, mem[0]);
    wait_gnt();
    host(1'b0, 1'b1, 1'b0, 18'h00010, 32'h00000002, rd);
    @(negedge i_clk);
    chk({30'h0, dgnt, brst}, 32'h1);
    repeat (10) @(negedge i_clk);
    chk({31'h0, dgnt}, 32'h0);
    i_ctl.drop_req();
    host(1'b0, 1'b1, 1'b0, 18'h00010, 32'h00000001, rd);
    @(negedge i_clk);
    chk({30'h0, brst, crst}, 32'h1);
    host(1'b0, 1'b1, 1'b0, 18'h00010, 32'h0000000C, rd);
    @(posedge i_clk);
    srst <= 1'b1;
    repeat (6) @(negedge i_clk);
    chk({30'h0, brst, crst}, 32'h1);
    @(posedge i_clk);
    srst <= 1'b0;
    repeat (6) @(negedge i_clk);
    chk({30'h0, brst, crst}, 32'h0);
    host(1'b0, 1'b1, 1'b0, 18'h00010, 32'h00000004, rd);
    @(posedge i_clk);
    srst <= 1'b1;
    repeat (6) @(negedge i_clk);
    chk({30'h0, brst, crst}, 32'h0);
    @(posedge i_clk);
    srst <= 1'b0;
    $display("test preempt and reset port done");
    end_of_test();
  end
endmodule
